// *** sirq_top.sv ***
// interrupt status, pin configuration and source enables of the sensor device
// How it works
// - frame-sync edge into the active level sets pass-through bit 7
// - reading aux status clears all its bits
// - slave-4 done sets bit 6, double-gated
// - arbitration loss sets bit 5
// - per-slave not-acknowledge sets bits 4..0
// - config bit 7 selects pin polarity
// - config bit 6 selects open-drain drive
// - config bit 5 latches, else 50us pulse
// - config bit 4 clears status on any read
// - config bit 3 selects frame-sync active level
// - config bit 2 enables frame-sync interrupts
// - config bit 1 bypasses idle aux pins
// - enable bit 6 gates wake-on-motion
// - enable bit 4 gates FIFO overflow
// - enable bit 3 gates frame sync
// - enable bit 0 gates raw ready, wait-timed
// - status bits 6,4,3,0 report the sources
`timescale 1ns/10ps
`include "sirq_regs.svh"
module sirq_top
   import sirq_pkg::*;
(
   input  wire logic       clock,          // 20 MHz device clock
   input  wire logic       rst,            // synchronous reset, active high
   input  wire logic [7:0] addr,           // register address
   input  wire logic [7:0] wr_data,        // register write data
   input  wire logic       wr_en,          // write strobe
   input  wire logic       rd_en,          // read strobe
   output logic      [7:0] rd_data,        // read data, cycle after strobe
   input  wire logic       frame_sync_pin, // asynchronous frame-sync input
   input  wire logic [4:0] slave_noack,    // not-acknowledge pulses, slaves 4..0
   input  wire logic       arb_lost,       // aux master lost arbitration pulse
   input  wire logic       slave_four_done,     // slave-4 transfer done pulse
   input  wire logic       slave_four_done_irq_enable, // from slave_four_control
   input  wire logic       aux_master_on,  // aux master interface enabled
   input  wire logic       motion_wake_evt,// wake-on-motion event pulse
   input  wire logic       fifo_ovf_evt,   // FIFO overflow event pulse
   input  wire logic       raw_data_evt,   // raw sensor data updated pulse
   input  wire logic       ext_sensor_done,// external sensor data fetched pulse
   output logic            irq_pin_o,      // interrupt pin output level
   output logic            irq_pin_oe,     // interrupt pin output enable
   output logic            aux_bypass,     // aux clock/data pins in bypass
   output logic            aux_float,      // aux pins released to pull-up
   output logic            sys_irq         // system-side level interrupt
);
   localparam int PULSE_CYC = `SIRQ_PULSE_NS / `SIRQ_CLK_NS;

   ////////////////////////////////////////////////////////////////////////////
   sirq_byte_t      aux_stat_q;
   sirq_byte_t      int_stat_q;
   sirq_byte_t      cfg_q;
   sirq_byte_t      en_q;
   sirq_byte_t      auxc_q;
   sirq_byte_t      loc_q;
   sirq_byte_t      evt_q;
   sirq_byte_t      mask_q;
   sirq_byte_t      aux_set;
   sirq_byte_t      int_set;
   sirq_byte_t      evt_set;
   sirq_pin_state_t pin_st_q;
   logic [9:0]      cnt_q;
   logic [2:0]      fs_sync_q;
   logic            fs_lvl_q;
   logic            fs_act_q;
   logic            raw_pend_q;
   logic            irq_act_q;
   logic            irq_act_d;
   logic            fs_rise;
   logic            raw_set;
   logic            irq_want;
   logic            new_irq;
   logic            wr_hit;
   logic            rd_aux;
   logic            rd_int;
   logic            clr_aux;
   logic            clr_int;
   logic            aux_en;

   assign wr_hit = wr_en;
   assign rd_aux = rd_en && addr == `SIRQ_OFF_AUX_STAT;
   assign rd_int = rd_en && addr == `SIRQ_OFF_INT_STAT;
   assign aux_en = loc_q[`SIRQ_LOC_AUX_IRQ];

   ////////////////////////////////////////////////////////////////////////////
   // frame sync: three stages, level accepted once stages two and three agree
   always_ff @(posedge clock) begin
      if (rst) begin
         fs_sync_q <= 3'h0;
         fs_lvl_q  <= 1'b0;
         fs_act_q  <= 1'b0;
      end else begin
         fs_sync_q <= {fs_sync_q[1:0], frame_sync_pin};
         if (fs_sync_q[1] == fs_sync_q[2]) begin
            fs_lvl_q <= fs_sync_q[2];
         end
         fs_act_q <= fs_lvl_q;
      end
   end

   // only a pin transition into the active level counts, not a held level;
   // flipping the polarity bit alone must not look like an edge
   assign fs_rise = cfg_q[`SIRQ_CFG_FS_IRQ]
                    && (cfg_q[`SIRQ_CFG_FS_LOW] ? (fs_act_q && !fs_lvl_q)
                                                : (!fs_act_q && fs_lvl_q));

   ////////////////////////////////////////////////////////////////////////////
   // raw ready waits for the external sensor fetch when asked to
   always_ff @(posedge clock) begin
      if (rst) begin
         raw_pend_q <= 1'b0;
      end else if (!auxc_q[`SIRQ_AUXC_WAIT] || ext_sensor_done) begin
         raw_pend_q <= 1'b0;
      end else if (raw_data_evt) begin
         raw_pend_q <= 1'b1;
      end
   end

   assign raw_set = auxc_q[`SIRQ_AUXC_WAIT]
                    ? ext_sensor_done && (raw_pend_q || raw_data_evt)
                    : raw_data_evt;

   always_comb begin
      aux_set = 8'h00;
      aux_set[`SIRQ_AUX_PASS]   = fs_rise;
      aux_set[`SIRQ_AUX_S4DONE] = slave_four_done;
      aux_set[`SIRQ_AUX_ARB]    = arb_lost;
      aux_set[4:0]              = slave_noack;
      int_set = 8'h00;
      int_set[`SIRQ_EN_MOTION] = motion_wake_evt;
      int_set[`SIRQ_EN_FIFO]   = fifo_ovf_evt;
      int_set[`SIRQ_EN_FRAME_SYNC_PIN]  = fs_rise;
      int_set[`SIRQ_EN_RAW]    = raw_set;
      evt_set = {2'b00, raw_set, fifo_ovf_evt, motion_wake_evt,
                 slave_four_done, arb_lost | (|slave_noack), fs_rise};
   end

   ////////////////////////////////////////////////////////////////////////////
   // status: a set in the clearing cycle survives the clear
   assign clr_aux = rd_aux || (rd_en && cfg_q[`SIRQ_CFG_ANY_RD]);
   assign clr_int = rd_int || (rd_en && cfg_q[`SIRQ_CFG_ANY_RD]);

   always_ff @(posedge clock) begin
      if (rst) begin
         aux_stat_q <= `SIRQ_RST_ZERO;
      end else begin
         aux_stat_q <= (clr_aux ? 8'h00 : aux_stat_q) | aux_set;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         int_stat_q <= `SIRQ_RST_ZERO;
      end else begin
         int_stat_q <= (clr_int ? 8'h00 : int_stat_q) | (int_set & `SIRQ_EN_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // writable registers; reserved bits are never stored
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q  <= `SIRQ_RST_CFG;
         en_q   <= `SIRQ_RST_EN;
         auxc_q <= `SIRQ_RST_ZERO;
         loc_q  <= `SIRQ_RST_ZERO;
         mask_q <= `SIRQ_RST_ZERO;
      end else if (wr_hit) begin
         case (addr)
            `SIRQ_OFF_PIN_CFG:  cfg_q  <= wr_data & `SIRQ_CFG_MASK;
            `SIRQ_OFF_SRC_EN:   en_q   <= wr_data & `SIRQ_EN_MASK;
            `SIRQ_OFF_AUX_CTRL: auxc_q <= wr_data & `SIRQ_AUXC_MASK;
            `SIRQ_OFF_LOC_CTRL: loc_q  <= wr_data & `SIRQ_LOC_MASK;
            `SIRQ_OFF_EVT_MASK: mask_q <= wr_data & `SIRQ_EVT_MASK;
            default: ;
         endcase
      end
   end

   // system events: sticky, write one to clear, set beats clear
   always_ff @(posedge clock) begin
      if (rst) begin
         evt_q <= `SIRQ_RST_ZERO;
      end else begin
         evt_q <= (evt_q & ~((wr_hit && addr == `SIRQ_OFF_EVT_STAT) ? wr_data : 8'h00))
                  | evt_set;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sys_irq <= 1'b0;
      end else begin
         sys_irq <= |(evt_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            `SIRQ_OFF_AUX_STAT: rd_data <= aux_stat_q;
            `SIRQ_OFF_PIN_CFG:  rd_data <= cfg_q;
            `SIRQ_OFF_SRC_EN:   rd_data <= en_q;
            `SIRQ_OFF_INT_STAT: rd_data <= int_stat_q;
            `SIRQ_OFF_AUX_CTRL: rd_data <= auxc_q;
            `SIRQ_OFF_LOC_CTRL: rd_data <= loc_q;
            `SIRQ_OFF_EVT_STAT: rd_data <= evt_q;
            `SIRQ_OFF_EVT_MASK: rd_data <= mask_q;
            default:            rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // which pending flags may drive the pin
   assign irq_want = (int_stat_q[`SIRQ_EN_MOTION] && en_q[`SIRQ_EN_MOTION])
                  || (int_stat_q[`SIRQ_EN_FIFO] && en_q[`SIRQ_EN_FIFO])
                  || ((int_stat_q[`SIRQ_EN_FRAME_SYNC_PIN] || aux_stat_q[`SIRQ_AUX_PASS])
                      && en_q[`SIRQ_EN_FRAME_SYNC_PIN])
                  || (int_stat_q[`SIRQ_EN_RAW] && en_q[`SIRQ_EN_RAW])
                  || (aux_en && (|aux_stat_q[5:0]))
                  || (aux_en && slave_four_done_irq_enable
                      && aux_stat_q[`SIRQ_AUX_S4DONE]);

   // a fresh enabled flag in this cycle starts a pulse
   assign new_irq = (motion_wake_evt && en_q[`SIRQ_EN_MOTION])
                 || (fifo_ovf_evt && en_q[`SIRQ_EN_FIFO])
                 || (fs_rise && en_q[`SIRQ_EN_FRAME_SYNC_PIN])
                 || (raw_set && en_q[`SIRQ_EN_RAW])
                 || (aux_en && ((|slave_noack) || arb_lost))
                 || (aux_en && slave_four_done_irq_enable && slave_four_done);

   // pulse mode: fixed width, a new event mid-pulse does not stretch it
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_st_q <= SIRQ_IDLE;
         cnt_q    <= 10'h000;
      end else begin
         case (pin_st_q)
            SIRQ_IDLE: begin
               if (new_irq && !cfg_q[`SIRQ_CFG_LATCH]) begin
                  pin_st_q <= SIRQ_PULSE;
                  cnt_q    <= 10'(PULSE_CYC - 1);
               end
            end
            SIRQ_PULSE: begin
               if (cnt_q == 10'h000) begin
                  pin_st_q <= SIRQ_IDLE;
               end else begin
                  cnt_q <= cnt_q - 10'h001;
               end
            end
            default: pin_st_q <= SIRQ_IDLE;
         endcase
      end
   end

   always_comb begin
      if (cfg_q[`SIRQ_CFG_LATCH]) begin
         irq_act_d = irq_want;
      end else begin
         irq_act_d = pin_st_q == SIRQ_PULSE;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq_act_q  <= 1'b0;
         irq_pin_o  <= 1'b0;
         irq_pin_oe <= 1'b1;
      end else begin
         irq_act_q  <= irq_act_d;
         irq_pin_o  <= irq_act_d ^ cfg_q[`SIRQ_CFG_POL_LOW];
         irq_pin_oe <= !cfg_q[`SIRQ_CFG_OPEN_DRAIN] || irq_act_d;
      end
   end

   // the aux master's own pin drive is elsewhere; these only steer idle pins
   always_ff @(posedge clock) begin
      if (rst) begin
         aux_bypass <= 1'b0;
         aux_float  <= 1'b1;
      end else begin
         aux_bypass <= cfg_q[`SIRQ_CFG_BYPASS] && !aux_master_on;
         aux_float  <= !cfg_q[`SIRQ_CFG_BYPASS] && !aux_master_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence fs_edge_s;
      fs_rise;
   endsequence
   sequence pulse_start_s;
      pin_st_q == SIRQ_IDLE && new_irq && !cfg_q[`SIRQ_CFG_LATCH];
   endsequence
   sequence pulse_run_s;
      pin_st_q == SIRQ_PULSE && cnt_q != 10'h000;
   endsequence

   frame_sync_pin_pass_bit_a: assert property (fs_edge_s |=> aux_stat_q[7] && int_stat_q[3])
      else $error("frame-sync edge did not set pass-through");
   aux_rd_clear_a: assert property (rd_aux && !(|aux_set) |=> aux_stat_q == 8'h00)
      else $error("aux status not cleared by read");
   s4_done_bit_a: assert property (slave_four_done |=> aux_stat_q[6])
      else $error("slave-4 done not recorded");
   arb_lost_bit_a: assert property (arb_lost |=> aux_stat_q[5])
      else $error("arbitration loss not recorded");
   noack_bits_a: assert property (|slave_noack |=>
      (aux_stat_q[4:0] & $past(slave_noack)) == $past(slave_noack))
      else $error("not-acknowledge not recorded");
   pin_level_a: assert property (irq_act_q |-> irq_pin_o == !cfg_q[7] || $changed(cfg_q))
      else $error("interrupt pin at wrong polarity");
   open_drain_a: assert property (cfg_q[6] && !irq_act_q && $stable(cfg_q) |-> !irq_pin_oe)
      else $error("open drain pin driven while idle");
   pulse_width_a: assert property (pulse_start_s |=> ##1 irq_act_q[*8])
      else $error("interrupt pulse too short");
   pulse_end_a: assert property (pin_st_q == SIRQ_PULSE && cnt_q == 10'h000 |=> ##1 !irq_act_q
      || cfg_q[5])
      else $error("interrupt pulse did not end");
   any_read_a: assert property (rd_en && cfg_q[4] && !(|int_set) |=> int_stat_q == 8'h00)
      else $error("any read did not clear status");
   fs_gate_a: assert property (!cfg_q[2] |-> !fs_rise)
      else $error("frame sync raised while disabled");
   motion_gate_a: assert property (cfg_q[5] && !en_q[6] && (int_stat_q & 8'hbf) == 8'h00
      && aux_stat_q == 8'h00 |-> !irq_act_d)
      else $error("masked motion source reached pin");
   reserved_zero_a: assert property ((cfg_q & 8'h01) == 8'h00 && (en_q & 8'ha6) == 8'h00)
      else $error("reserved bit stored");
   fs_level_sel_a: assert property (fs_rise |-> fs_lvl_q != cfg_q[3] && $past(fs_lvl_q) == cfg_q[3])
      else $error("frame-sync edge at wrong level");
   bypass_idle_a: assert property (!aux_master_on |=>
      aux_bypass == $past(cfg_q[1]) && aux_float == !$past(cfg_q[1]))
      else $error("idle aux pins in wrong mode");
   bypass_busy_a: assert property (aux_master_on |=> !aux_bypass && !aux_float)
      else $error("aux pins steered while master on");
   fifo_gate_a: assert property (cfg_q[5] && !en_q[4] && (int_stat_q & 8'hef) == 8'h00
      && aux_stat_q == 8'h00 |-> !irq_act_d)
      else $error("masked fifo source reached pin");
   frame_sync_pin_gate_a: assert property (cfg_q[5] && !en_q[3] && (int_stat_q & 8'hf7) == 8'h00
      && (aux_stat_q & 8'h7f) == 8'h00 |-> !irq_act_d)
      else $error("masked frame-sync source reached pin");
   raw_gate_a: assert property (cfg_q[5] && !en_q[0] && (int_stat_q & 8'hfe) == 8'h00
      && aux_stat_q == 8'h00 |-> !irq_act_d)
      else $error("masked raw-ready source reached pin");
   raw_wait_a: assert property (auxc_q[6] && !ext_sensor_done && !int_stat_q[0] |=> !int_stat_q[0])
      else $error("raw ready set before external fetch");
   raw_direct_a: assert property (!auxc_q[6] && raw_data_evt |=> int_stat_q[0])
      else $error("raw ready not recorded");
   motion_bit_a: assert property (motion_wake_evt |=> int_stat_q[6])
      else $error("wake-on-motion not recorded");
   fifo_bit_a: assert property (fifo_ovf_evt |=> int_stat_q[4])
      else $error("fifo overflow not recorded");
   int_rd_clear_a: assert property (rd_int && !(|int_set) |=> int_stat_q == 8'h00)
      else $error("interrupt status not cleared by read");
   latch_follow_a: assert property (cfg_q[5] && irq_want |=> irq_act_q)
      else $error("latched pin missed a pending flag");
   pulse_count_a: assert property (pulse_run_s |=>
      pin_st_q == SIRQ_PULSE && cnt_q == $past(cnt_q) - 10'h001)
      else $error("pulse counter skipped");
   cfg_write_a: assert property (wr_en && addr == `SIRQ_OFF_PIN_CFG |=>
      cfg_q == ($past(wr_data) & `SIRQ_CFG_MASK))
      else $error("config write not stored");
   en_write_a: assert property (wr_en && addr == `SIRQ_OFF_SRC_EN |=>
      en_q == ($past(wr_data) & `SIRQ_EN_MASK))
      else $error("enable write not stored");
   drain_active_a: assert property (cfg_q[6] && irq_act_q && $stable(cfg_q) |-> irq_pin_oe)
      else $error("open drain pin not driven while active");
   pin_idle_a: assert property (!irq_act_q && $stable(cfg_q) |-> irq_pin_o == cfg_q[7])
      else $error("idle interrupt pin at wrong level");
endmodule

// *** sirq_regs.svh ***
// register offsets, field positions, reset values and timing for the interrupt block
`ifndef SIRQ_REGS_SVH
`define SIRQ_REGS_SVH
`define SIRQ_OFF_AUX_CTRL   8'h24
`define SIRQ_OFF_AUX_STAT   8'h36
`define SIRQ_OFF_PIN_CFG    8'h37
`define SIRQ_OFF_SRC_EN     8'h38
`define SIRQ_OFF_INT_STAT   8'h3a
`define SIRQ_OFF_EVT_STAT   8'h70
`define SIRQ_OFF_EVT_MASK   8'h71
`define SIRQ_OFF_LOC_CTRL   8'h72
`define SIRQ_AUX_PASS       7
`define SIRQ_AUX_S4DONE     6
`define SIRQ_AUX_ARB        5
`define SIRQ_CFG_POL_LOW    7
`define SIRQ_CFG_OPEN_DRAIN 6
`define SIRQ_CFG_LATCH      5
`define SIRQ_CFG_ANY_RD     4
`define SIRQ_CFG_FS_LOW     3
`define SIRQ_CFG_FS_IRQ     2
`define SIRQ_CFG_BYPASS     1
`define SIRQ_EN_MOTION      6
`define SIRQ_EN_FIFO        4
`define SIRQ_EN_FRAME_SYNC_PIN       3
`define SIRQ_EN_RAW         0
`define SIRQ_AUXC_WAIT      6
`define SIRQ_LOC_AUX_IRQ    0
`define SIRQ_CFG_MASK       8'hfe
`define SIRQ_EN_MASK        8'h59
`define SIRQ_AUXC_MASK      8'h40
`define SIRQ_LOC_MASK       8'h01
`define SIRQ_EVT_MASK       8'h3f
`define SIRQ_RST_CFG        8'h00
`define SIRQ_RST_EN         8'h00
`define SIRQ_RST_ZERO       8'h00
`define SIRQ_PULSE_NS       50000
`define SIRQ_CLK_NS         50
`endif

// *** sirq_pkg.sv ***
// types shared by the sensor interrupt block
package sirq_pkg;
   typedef enum logic [1:0] {
      SIRQ_IDLE  = 2'b00,
      SIRQ_PULSE = 2'b01
   } sirq_pin_state_t;
   typedef logic [7:0] sirq_byte_t;
endpackage

// *** sirq_host.sv ***
// host-side model: resolves the interrupt wire and times each active spell
`timescale 1ns/10ps
module sirq_host (
   input  wire logic clock,      // device clock
   input  wire logic irq_pin_o,  // device pin level
   input  wire logic irq_pin_oe, // device pin enable
   input  wire logic pol_low,    // host expects an active-low pin
   output logic      irq_wire,   // resolved wire level
   output logic      irq_seen,   // host sees an interrupt
   output int        last_len    // cycles of the last active spell
);
   int run = 0;
   // board pull-up holds the wire high once the device lets go
   assign irq_wire = irq_pin_oe ? irq_pin_o : 1'b1;
   assign irq_seen = irq_wire ^ pol_low;
   always @(posedge clock) begin
      if (irq_seen === 1'b1) begin
         run <= run + 1;
      end else begin
         if (run != 0) begin
            last_len <= run;
         end
         run <= 0;
      end
   end
endmodule

// *** sensor_irq_status_config_tb.sv ***
// self-checking bench for the sensor interrupt status and pin configuration block
`timescale 1ns/10ps
`include "sirq_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sensor_irq_status_config_tb
   import sirq_pkg::*;
;
   localparam logic [10:0] ev_mot = 11'h080, ev_fifo = 11'h100, ev_raw = 11'h200, ev_ext = 11'h400;
   logic       clock, rst, wr_en, rd_en, fs, s4_ien, aux_on, pol_low;
   sirq_byte_t addr, wr_data, rd_data, v;
   logic [10:0] evts;
   logic [6:0] m;
   logic       irq_pin_o, irq_pin_oe, aux_bypass, aux_float, sys_irq, irq_wire, irq_seen;
   int         last_len;
   int         n_tests = 0;
   int         n_mismatch = 0;

   sirq_top i_dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .frame_sync_pin(fs), .slave_noack(evts[4:0]),
      .arb_lost(evts[5]), .slave_four_done(evts[6]), .slave_four_done_irq_enable(s4_ien),
      .aux_master_on(aux_on), .motion_wake_evt(evts[7]), .fifo_ovf_evt(evts[8]),
      .raw_data_evt(evts[9]), .ext_sensor_done(evts[10]), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe), .aux_bypass(aux_bypass), .aux_float(aux_float), .sys_irq(sys_irq));
   sirq_host i_host (.clock(clock), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
      .pol_low(pol_low), .irq_wire(irq_wire), .irq_seen(irq_seen), .last_len(last_len));

   initial clock = 1'b0;
   always #25 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic sirq_byte_t one_hot(input int i);
      return sirq_byte_t'(1 << i);
   endfunction
   task automatic wr(input sirq_byte_t a, input sirq_byte_t d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      // host tracks the pin polarity it was told to expect
      if (a == `SIRQ_OFF_PIN_CFG) begin
         pol_low <= d[7];
      end
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rchk(input sirq_byte_t a, input sirq_byte_t e);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      `CHK(rd_data, e)
   endtask
   task automatic pulse(input logic [10:0] p);
      @(posedge clock);
      evts <= p;
      @(posedge clock);
      evts <= '0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic finish_test;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // about 1400 cycles are needed; the limit leaves ample slack
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      finish_test;
   end

   initial begin
      rst = 1'b1;
      addr = '0;
      wr_data = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      evts = '0;
      fs = 1'b0;
      s4_ien = 1'b0;
      aux_on = 1'b0;
      pol_low = 1'b0;
      v = '0;
      m = '0;
      void'($urandom(78122));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rchk(8'h37, 8'h00);
      rchk(8'h38, 8'h00);
      rchk(8'h10, 8'h00);
      `CHK(aux_float, 1'b1)
      for (int i = 0; i < 6; i++) begin
         v = sirq_byte_t'($urandom);
         wr(8'h37, v);
         wr(8'h38, v);
         rchk(8'h37, v & `SIRQ_CFG_MASK);
         rchk(8'h38, v & `SIRQ_EN_MASK);
         `CHK({aux_bypass, aux_float}, {v[1], ~v[1]})
      end
      @(posedge clock);
      aux_on <= 1'b1;
      idle(2);
      `CHK({aux_bypass, aux_float}, 2'b00)
      @(posedge clock);
      aux_on <= 1'b0;
      // latched pin until the pulse width test, so no 1000-cycle pulse runs on into other sections
      wr(8'h37, 8'h20);
      wr(8'h38, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 7; i++) begin
         pulse(11'(one_hot(i)));
         rchk(8'h36, one_hot(i));
         rchk(8'h36, 8'h00);
      end
      repeat (4) begin
         m = 7'($urandom);
         pulse({4'h0, m});
         rchk(8'h36, {1'b0, m});
      end
      $display("test aux status done");
      wr(8'h72, 8'h01);
      wr(8'h71, 8'h06);
      s4_ien <= 1'b1;
      for (int i = 5; i < 7; i++) begin
         pulse(11'(one_hot(i)));
         idle(2);
         `CHK(sys_irq, 1'b1)
         `CHK(irq_seen, 1'b1)
         wr(8'h70, 8'h3f);
         idle(2);
         `CHK(sys_irq, 1'b0)
         rchk(8'h36, one_hot(i));
      end
      s4_ien <= 1'b0;
      pulse(11'h040);
      idle(2);
      `CHK(irq_seen, 1'b0)
      `CHK(sys_irq, 1'b1)
      wr(8'h72, 8'h00);
      pulse(11'h001);
      idle(2);
      `CHK(irq_seen, 1'b0)
      rchk(8'h36, 8'h41);
      wr(8'h70, 8'h3f);
      $display("test aux interrupt done");
      wr(8'h38, 8'h08);
      wr(8'h37, 8'h24);
      @(posedge clock);
      fs <= 1'b1;
      idle(8);
      `CHK(irq_seen, 1'b1)
      rchk(8'h36, 8'h80);
      rchk(8'h3a, 8'h08);
      idle(2);
      `CHK(irq_seen, 1'b0)
      wr(8'h37, 8'h2c);
      @(posedge clock);
      fs <= 1'b0;
      idle(8);
      rchk(8'h36, 8'h80);
      rchk(8'h3a, 8'h08);
      wr(8'h37, 8'h20);
      @(posedge clock);
      fs <= 1'b1;
      idle(8);
      rchk(8'h36, 8'h00);
      $display("test frame sync done");
      wr(8'h38, 8'h40);
      pulse(ev_fifo);
      idle(3);
      `CHK(irq_seen, 1'b0)
      rchk(8'h3a, 8'h10);
      pulse(ev_mot);
      idle(3);
      `CHK({irq_pin_oe, irq_pin_o}, 2'b11)
      idle(20);
      `CHK(irq_seen, 1'b1)
      rchk(8'h3a, 8'h40);
      idle(2);
      `CHK(irq_seen, 1'b0)
      wr(8'h37, 8'ha0);
      idle(2);
      `CHK(irq_pin_o, 1'b1)
      wr(8'h37, 8'h60);
      idle(2);
      `CHK(irq_pin_oe, 1'b0)
      pulse(ev_mot);
      idle(3);
      `CHK({irq_pin_oe, irq_pin_o}, 2'b11)
      rchk(8'h3a, 8'h40);
      wr(8'h37, 8'h30);
      pulse(ev_mot);
      idle(3);
      rchk(8'h38, 8'h40);
      idle(2);
      `CHK(irq_seen, 1'b0)
      rchk(8'h3a, 8'h00);
      $display("test pin modes done");
      wr(8'h37, 8'h00);
      wr(8'h38, 8'h10);
      pulse(ev_fifo);
      idle(1100);
      `CHK(last_len, 50000 / 50)
      rchk(8'h3a, 8'h10);
      $display("test pulse width done");
      wr(8'h37, 8'h20);
      wr(8'h38, 8'h01);
      pulse(ev_mot);
      idle(3);
      `CHK(irq_seen, 1'b0)
      rchk(8'h3a, 8'h40);
      wr(8'h24, 8'h40);
      pulse(ev_raw);
      idle(2);
      rchk(8'h3a, 8'h00);
      pulse(ev_ext);
      idle(3);
      `CHK(irq_seen, 1'b1)
      rchk(8'h3a, 8'h01);
      wr(8'h24, 8'h00);
      pulse(ev_raw);
      rchk(8'h3a, 8'h01);
      $display("test raw ready done");
      finish_test;
   end
endmodule
